// ### hdl/sgm_link_latch.sv
// Latching-low link status bit, reloaded by a read of the status register
`timescale 1ns/100ps
module sgm_link_latch
  import sgm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_sync,
  input wire logic read_pulse,
  output logic link_bit
);

  // ==========================================================
  // Latch
  // A read reloads the live level; otherwise any drop sticks at zero
  // until software comes back for it, so a short outage is never missed
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      link_bit <= LINK_RESET;
    end else if (read_pulse) begin
      link_bit <= link_sync;
    end else if (!link_sync) begin
      link_bit <= 1'b0;
    end
  end

endmodule // sgm_link_latch

// ### hdl/sgm_mgmt_regs.sv
// Management register set and frame slave of the serial-link PCS
//
// How it works
// - Status bits 15:9 always read zero
// - Status bit 8 reads one: extended status
// - Status bit 7 reads one, writes ignored
// - Status bit 6 reads one: no preamble needed
// - Status bits 5:3 zero; software ignores them
// - Link bit latches low when link drops
// - Status read reloads link bit from live status
// - Link one only if continuously up since read
// - Status bits 1 and 0 read zero
// - Registers 2 and 3 return fixed identity
// - Register 4 read-only, only bit 0 set
// - Extended status bit 15 reads one
// - Extended status bits 14:0 read zero
// - Register 17 exists only with dynamic switching
// - Register 17 bit 0 selects standard; rest zero
// - Standard bit resets from select input
// - Standard register writable at any time
// - Undefined addresses read zero, ignore writes
// - Every reset source restores all defaults
`timescale 1ns/100ps
module sgm_mgmt_regs
  import sgm_pkg::*;
#(
  parameter bit DYNAMIC_SWITCH = 1'b1,
  parameter logic [21:0] ORG_CODE = 22'h15A3C5, // Arbitrary value
  parameter logic [5:0] MODEL_CODE = 6'h2B, // Arbitrary value
  parameter logic [3:0] REV_CODE = 4'h3 // Arbitrary value
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic clock_lock_reset_source,
  input wire logic basex_or_sgmii,
  input wire logic link_sync,
  input wire logic [4:0] phy_address,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_tri,
  output logic standard_sgmii
);

  // ==========================================================
  // Core reset and clock edge detect
  logic core_rst_n;
  logic mdc_q;
  logic mdc_rise;
  sgm_state_t state;
  sgm_hdr_t hdr;
  logic [4:0] bit_cnt;
  logic [15:0] rd_word;
  logic reading;
  logic writing;
  logic load_rd;
  logic read_pulse;
  logic link_bit;
  logic std_sel;
  logic [4:0] last_reg;
  logic addr_match;

  // Any of the three sources puts the whole register set back
  assign core_rst_n = rst_n && !soft_reset && clock_lock_reset_source;

  // Management clock pin is synchronous, so a plain delay finds its edge
  always_ff @(posedge clock) begin
    if (!core_rst_n) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
    end
  end

  assign mdc_rise = mdc && !mdc_q;

  // Register number complete on the last address bit
  assign last_reg = {hdr.regad[3:0], mdio_in};
  assign addr_match = (hdr.phy == phy_address);

  // Header fully received, read frame aimed at this device
  assign load_rd = mdc_rise && (state == S_REG) && (bit_cnt == ADDR_LAST)
    && (hdr.op == OP_READ) && addr_match;
  assign read_pulse = load_rd && (last_reg == REG_STATUS);

  // ==========================================================
  // Read multiplexer
  function automatic logic [15:0] read_reg(input logic [4:0] a,
                                           input logic link,
                                           input logic std);
    logic [15:0] v;
    v = UNMAPPED_VALUE;
    unique case (a)
      REG_STATUS: begin
        // Fixed abilities plus the latched link bit
        v = STATUS_FIXED;
        v[LINK_BIT_POS] = link;
      end
      REG_ID_HIGH: v = ORG_CODE[21:6];
      REG_ID_LOW: v = {ORG_CODE[5:0], MODEL_CODE, REV_CODE};
      REG_ADVERT: v = ADVERT_VALUE;
      REG_EXT_STATUS: v = EXT_STATUS_VALUE;
      REG_STD_SELECT: begin
        // Absent builds leave the address undefined, reading zero
        if (DYNAMIC_SWITCH) begin
          v = {15'h0000, std};
        end
      end
      default: v = UNMAPPED_VALUE;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Frame decoder
  // Idle line is high; the first zero is the start, so no preamble
  // is needed and a preamble of ones is simply skipped
  always_ff @(posedge clock) begin
    if (!core_rst_n) begin
      state <= S_IDLE;
      bit_cnt <= 5'h00;
      hdr <= '0;
    end else if (mdc_rise) begin
      unique case (state)
        S_IDLE: begin
          if (!mdio_in) begin
            state <= S_START;
          end
        end
        S_START: begin
          state <= mdio_in ? S_OP : S_IDLE;
          bit_cnt <= 5'h00;
        end
        S_OP: begin
          hdr.op <= {hdr.op[0], mdio_in};
          bit_cnt <= (bit_cnt == OP_LAST) ? 5'h00 : bit_cnt + 5'h01;
          if (bit_cnt == OP_LAST) begin
            state <= S_PHY;
          end
        end
        S_PHY: begin
          hdr.phy <= {hdr.phy[3:0], mdio_in};
          bit_cnt <= (bit_cnt == ADDR_LAST) ? 5'h00 : bit_cnt + 5'h01;
          if (bit_cnt == ADDR_LAST) begin
            state <= S_REG;
          end
        end
        S_REG: begin
          hdr.regad <= last_reg;
          bit_cnt <= (bit_cnt == ADDR_LAST) ? 5'h00 : bit_cnt + 5'h01;
          if (bit_cnt == ADDR_LAST) begin
            state <= S_TA;
          end
        end
        S_TA: begin
          bit_cnt <= (bit_cnt == TA_LAST) ? 5'h00 : bit_cnt + 5'h01;
          if (bit_cnt == TA_LAST) begin
            state <= S_DATA;
          end
        end
        S_DATA: begin
          bit_cnt <= (bit_cnt == DATA_LAST) ? 5'h00 : bit_cnt + 5'h01;
          if (bit_cnt == DATA_LAST) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Frame kind flags
  // Frames for another PHY address leave the pin released
  always_ff @(posedge clock) begin
    if (!core_rst_n) begin
      reading <= 1'b0;
      writing <= 1'b0;
    end else if (mdc_rise && state == S_REG && bit_cnt == ADDR_LAST) begin
      reading <= (hdr.op == OP_READ) && addr_match;
      writing <= (hdr.op == OP_WRITE) && addr_match;
    end else if (mdc_rise && state == S_IDLE) begin
      reading <= 1'b0;
      writing <= 1'b0;
    end
  end

  // ==========================================================
  // Read data path
  // The word is frozen at header end, so a link drop during the data
  // phase shows only on the next read
  always_ff @(posedge clock) begin
    if (!core_rst_n) begin
      rd_word <= 16'h0000;
    end else if (load_rd) begin
      rd_word <= read_reg(last_reg, link_bit, std_sel);
    end else if (mdc_rise && reading && (state == S_DATA
                 || (state == S_TA && bit_cnt == TA_LAST))) begin
      rd_word <= {rd_word[14:0], 1'b0};
    end
  end

  // Pin drive: zero in the second turnaround bit, then data MSB first
  always_ff @(posedge clock) begin
    if (!core_rst_n) begin
      mdio_out <= 1'b1;
      mdio_tri <= 1'b1;
    end else if (mdc_rise && reading) begin
      if (state == S_TA && bit_cnt == 5'h00) begin
        mdio_out <= 1'b0;
        mdio_tri <= 1'b0;
      end else if (state == S_TA || (state == S_DATA
                   && bit_cnt != DATA_LAST)) begin
        mdio_out <= rd_word[15];
        mdio_tri <= 1'b0;
      end else begin
        mdio_out <= 1'b1;
        mdio_tri <= 1'b1;
      end
    end else if (mdc_rise && state == S_IDLE) begin
      mdio_out <= 1'b1;
      mdio_tri <= 1'b1;
    end
  end

  // ==========================================================
  // Write data path
  // Only the last data bit is ever kept, so no shift register is built
  // Standard select: loaded from the strap on every reset; writes to all
  // other registers are dropped, which keeps them read-only
  always_ff @(posedge clock) begin
    if (!core_rst_n) begin
      std_sel <= basex_or_sgmii;
    end else if (mdc_rise && writing && state == S_DATA
                 && bit_cnt == DATA_LAST && DYNAMIC_SWITCH
                 && hdr.regad == REG_STD_SELECT) begin
      std_sel <= mdio_in;
    end
  end

  // Drives the datapath selection of the core
  always_ff @(posedge clock) begin
    if (!core_rst_n) begin
      standard_sgmii <= 1'b0;
    end else begin
      standard_sgmii <= std_sel;
    end
  end

  // ==========================================================
  // Link status latch
  sgm_link_latch u_link (
    .clock(clock),
    .rst_n(core_rst_n),
    .link_sync(link_sync),
    .read_pulse(read_pulse),
    .link_bit(link_bit)
  );

  // ==========================================================
  // Checks
  a_status_upper_zero: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    read_pulse |=> (rd_word[15:9] == 7'h00))
    else $error("status bits 15:9 not zero");

  a_status_ext_one: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    read_pulse |=> rd_word[8])
    else $error("status extended bit not one");

  a_status_unidir_one: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    read_pulse |=> rd_word[7])
    else $error("unidirectional bit not one");

  a_status_pre_one: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    read_pulse |=> rd_word[6])
    else $error("preamble suppression bit not one");

  a_status_neg_zero: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    read_pulse |=> (rd_word[5:3] == 3'h0 && rd_word[1:0] == 2'h0))
    else $error("negotiation or low status bits set");

  a_link_latch_low: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    (!link_sync && !read_pulse) |=> !link_bit)
    else $error("link bit did not latch low");

  // Only a read may bring the latched zero back up
  a_link_hold_low: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    (!link_bit && !read_pulse) |=> !link_bit)
    else $error("link bit rose without a read");

  a_link_reload: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    read_pulse |=> (link_bit == $past(link_sync)))
    else $error("link bit not reloaded on read");

  a_link_read_value: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    read_pulse |=> (rd_word[LINK_BIT_POS] == $past(link_bit)))
    else $error("read link bit differs from latch");

  a_ident_fixed: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    (load_rd && last_reg == REG_ID_HIGH) |=> (rd_word == ORG_CODE[21:6]))
    else $error("identifier high wrong");

  a_advert_fixed: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    (load_rd && last_reg == REG_ADVERT) |=> (rd_word == 16'h0001))
    else $error("advertisement register wrong");

  a_ext_status: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    (load_rd && last_reg == REG_EXT_STATUS) |=> (rd_word == 16'h8000))
    else $error("extended status wrong");

  a_std_write: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    (mdc_rise && writing && state == S_DATA && bit_cnt == DATA_LAST
     && hdr.regad == REG_STD_SELECT && DYNAMIC_SWITCH)
    |=> (std_sel == $past(mdio_in)) ##1 (standard_sgmii == std_sel))
    else $error("standard select write lost");

  a_std_pin_follow: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    core_rst_n |=> (standard_sgmii == $past(std_sel)))
    else $error("standard pin does not follow select bit");

  a_undef_zero: assert property (
    @(posedge clock) disable iff (!core_rst_n)
    (load_rd && (last_reg == 5'h05 || last_reg == 5'h1F))
    |=> (rd_word == 16'h0000))
    else $error("undefined register not zero");

  a_reset_default: assert property (
    @(posedge clock)
    !core_rst_n |=> (!link_bit && mdio_tri && std_sel == $past(basex_or_sgmii)))
    else $error("reset did not restore defaults");

endmodule // sgm_mgmt_regs

// ### hdl/sgm_pkg.sv
// Shared constants and types for the serial-link management registers
package sgm_pkg;

  // ==========================================================
  // Register numbers on the management bus
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_ID_HIGH = 5'h02;
  localparam logic [4:0] REG_ID_LOW = 5'h03;
  localparam logic [4:0] REG_ADVERT = 5'h04;
  localparam logic [4:0] REG_EXT_STATUS = 5'h0F;
  localparam logic [4:0] REG_STD_SELECT = 5'h11;

  // ==========================================================
  // Fixed register contents and field positions
  localparam logic [15:0] STATUS_FIXED = 16'h01C0;
  localparam int LINK_BIT_POS = 2;
  localparam logic [15:0] ADVERT_VALUE = 16'h0001;
  localparam logic [15:0] EXT_STATUS_VALUE = 16'h8000;
  localparam logic [15:0] UNMAPPED_VALUE = 16'h0000;
  localparam logic [4:0] ORG_LOW_POS = 5'h0A;
  localparam logic [4:0] MODEL_POS = 5'h04;
  localparam logic LINK_RESET = 1'h0;

  // ==========================================================
  // Frame layout
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] OP_LAST = 5'h01;
  localparam logic [4:0] ADDR_LAST = 5'h04;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0F;

  // Frame decoder states
  typedef enum logic [2:0] {
    S_IDLE, S_START, S_OP, S_PHY, S_REG, S_TA, S_DATA
  } sgm_state_t;

  // Header of one management frame
  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regad;
  } sgm_hdr_t;

endpackage

// ### testbench/sgm_mgmt_station.sv
// Management station model that clocks frames into the register block
`timescale 1ns/100ps
module sgm_mgmt_station
  import sgm_pkg::*;
(
  input wire logic clock,
  input wire logic mdio_out,
  input wire logic mdio_tri,
  output logic mdc,
  output logic mdio_in
);
  // ==========================================================
  // Wire level
  logic drive_bit;
  // Released line is pulled high, never left at the last value
  assign mdio_in = mdio_tri ? drive_bit : mdio_out;
  initial begin
    mdc = 1'b0;
    drive_bit = 1'b1;
  end
  // ==========================================================
  // One whole frame, MSB first; half is the mdc low time in clocks, high lasts one clock more
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       input int half, output logic [15:0] rd);
    logic [31:0] bits;
    bits = {2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      @(negedge clock);
      // Turnaround and data of a read are left to the device
      drive_bit = (op == OP_READ && i < 18) ? 1'b1 : bits[i];
      mdc = 1'b0;
      repeat (half) @(negedge clock);
      // Bit launched by the previous rise still stands here
      if (i < 16) rd[i] = mdio_in;
      mdc = 1'b1;
      repeat (half) @(negedge clock);
    end
    // Clock stands still between frames
    mdc = 1'b0;
    drive_bit = 1'b1;
  endtask
endmodule // sgm_mgmt_station

// ### testbench/tb_top.sv
// Self-checking bench for the management register block
`timescale 1ns/100ps
module tb_top
  import sgm_pkg::*;
;
  localparam logic [21:0] ORG = 22'h2C1D37; // Arbitrary value
  localparam logic [5:0] MODEL = 6'h15; // Arbitrary value
  localparam logic [3:0] REV = 4'hA; // Arbitrary value
  localparam logic [4:0] PHY = 5'h05;
  localparam logic [4:0] PHY_B = 5'h06;
  logic out_b, tri_b, std_b, bus_out, bus_tri;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset = 1'b0;
  logic lock = 1'b1;
  logic strap = 1'b1;
  logic link_sync = 1'b1;
  logic mdc, mdio_in, mdio_out, mdio_tri, standard_sgmii;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [15:0] v;
  logic [4:0] holes [3] = '{5'h00, 5'h10, 5'h1F};

  always #2.5 clock = ~clock;

  sgm_mgmt_regs #(.DYNAMIC_SWITCH(1'b1), .ORG_CODE(ORG),
    .MODEL_CODE(MODEL), .REV_CODE(REV)) dut (.clock(clock),
    .rst_n(rst_n), .soft_reset(soft_reset),
    .clock_lock_reset_source(lock), .basex_or_sgmii(strap),
    .link_sync(link_sync), .phy_address(PHY), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_tri(mdio_tri),
    .standard_sgmii(standard_sgmii));
  // Second build without the selection register, on its own address
  sgm_mgmt_regs #(.DYNAMIC_SWITCH(1'b0), .ORG_CODE(ORG),
    .MODEL_CODE(MODEL), .REV_CODE(REV)) dut_fixed (.clock(clock),
    .rst_n(rst_n), .soft_reset(soft_reset),
    .clock_lock_reset_source(lock), .basex_or_sgmii(strap),
    .link_sync(link_sync), .phy_address(PHY_B), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(out_b), .mdio_tri(tri_b),
    .standard_sgmii(std_b));
  // Shared wire: whichever slave is driving wins
  assign bus_tri = mdio_tri && tri_b;
  assign bus_out = mdio_tri ? out_b : mdio_out;
  sgm_mgmt_station mgr (.clock(clock), .mdio_out(bus_out),
    .mdio_tri(bus_tri), .mdc(mdc), .mdio_in(mdio_in));

  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [15:0] ex, got);
    n_checks++;
    if (got !== ex) begin
      $display("ERROR %s expected %h seen %h", nm, ex, got);
      miscompares++;
    end
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] ra,
                        input logic [15:0] ex);
    logic [15:0] val;
    mgr.frame(OP_READ, PHY, ra, 16'h0000, 4, val);
    check(nm, ex, val);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] val);
    logic [15:0] unused;
    mgr.frame(OP_WRITE, PHY, ra, val, 4, unused);
  endtask

  // ==========================================================
  // Scenarios
  // Link bit starts low, so only the second read shows it up
  task automatic t_fixed();
    rd_chk("status first", REG_STATUS, 16'h01C0);
    rd_chk("status", REG_STATUS, 16'h01C4);
    rd_chk("id high", REG_ID_HIGH, ORG[21:6]);
    rd_chk("id low", REG_ID_LOW, {ORG[5:0], MODEL, REV});
    rd_chk("advert", REG_ADVERT, 16'h0001);
    rd_chk("ext status", REG_EXT_STATUS, 16'h8000);
    rd_chk("std select", REG_STD_SELECT, 16'h0001);
    foreach (holes[i]) rd_chk("unmapped", holes[i], 16'h0000);
    $display("t_fixed done");
  endtask
  // A one-clock drop must be remembered until read
  task automatic t_latch();
    @(negedge clock);
    link_sync = 1'b0;
    @(negedge clock);
    link_sync = 1'b1;
    rd_chk("latched low", REG_STATUS, 16'h01C0);
    rd_chk("reread", REG_STATUS, 16'h01C4);
    link_sync = 1'b0;
    rd_chk("link down", REG_STATUS, 16'h01C0);
    link_sync = 1'b1;
    rd_chk("stale until read", REG_STATUS, 16'h01C0);
    rd_chk("live again", REG_STATUS, 16'h01C4);
    $display("t_latch done");
  endtask
  // Writable selection, read-only status, advert and hole 5, foreign address
  task automatic t_write();
    wr(REG_STD_SELECT, 16'hFFFE);
    rd_chk("std cleared", REG_STD_SELECT, 16'h0000);
    check("std pin low", 16'h0000, {15'h0000, standard_sgmii});
    wr(REG_STD_SELECT, 16'h0001);
    mgr.frame(OP_READ, PHY, REG_STD_SELECT, 16'h0000, 1, v);
    check("std fast read", 16'h0001, v);
    check("std pin high", 16'h0001, {15'h0000, standard_sgmii});
    wr(REG_STATUS, 16'h0000);
    rd_chk("status kept", REG_STATUS, 16'h01C4);
    wr(REG_ADVERT, 16'hFFFF);
    rd_chk("advert kept", REG_ADVERT, 16'h0001);
    wr(5'h05, 16'hFFFF);
    rd_chk("hole kept", 5'h05, 16'h0000);
    mgr.frame(OP_READ, PHY ^ 5'h01, REG_STD_SELECT, 16'h0000, 4, v);
    check("other phy", 16'hFFFF, v);
    $display("t_write done");
  endtask
  // Soft reset and loss of lock reload defaults from the strap
  task automatic t_reset();
    strap = 1'b0;
    soft_reset = 1'b1;
    repeat (2) @(negedge clock);
    soft_reset = 1'b0;
    repeat (2) @(negedge clock);
    rd_chk("soft std", REG_STD_SELECT, 16'h0000);
    rd_chk("soft link", REG_STATUS, 16'h01C0);
    strap = 1'b1;
    lock = 1'b0;
    repeat (2) @(negedge clock);
    check("pin in reset", 16'h0000, {15'h0000, standard_sgmii});
    lock = 1'b1;
    repeat (2) @(negedge clock);
    rd_chk("lock std", REG_STD_SELECT, 16'h0001);
    $display("t_reset done");
  endtask
  // Build without switching: address 17 undefined, pin keeps the strap
  task automatic t_absent();
    mgr.frame(OP_READ, PHY_B, REG_ADVERT, 16'h0000, 4, v);
    check("fixed advert", 16'h0001, v);
    mgr.frame(OP_WRITE, PHY_B, REG_STD_SELECT, 16'h0000, 4, v);
    mgr.frame(OP_READ, PHY_B, REG_STD_SELECT, 16'h0000, 4, v);
    check("fixed std absent", 16'h0000, v);
    check("fixed std pin", 16'h0001, {15'h0000, std_b});
    $display("t_absent done");
  endtask

  // ==========================================================
  // Closing
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog: 32 frames of under 300 clocks each
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    t_fixed();
    t_latch();
    t_write();
    t_reset();
    t_absent();
    final_report();
  end
endmodule // tb_top
